// File: src/dbm_pkg.sv
/*
 doorbell message register bank: offsets, field positions, reset values, codes.
 assumes a word-addressed slave port with byte offsets on a 32-bit data bus.
*/
package dbm_pkg;
	localparam logic [5:0] OFF_RX_MESSAGE_HEAD = 6'h00;
	localparam logic [5:0] OFF_RX_QUEUE_COUNT = 6'h04;
	localparam logic [5:0] OFF_TX_REQUEST_PRIORITY = 6'h08;
	localparam logic [5:0] OFF_TX_MESSAGE_WORD = 6'h0C;
	localparam logic [5:0] OFF_TX_PROGRESS_COUNTS = 6'h10;
	localparam logic [5:0] OFF_TX_RESULT_HEAD = 6'h14;
	localparam logic [5:0] OFF_TX_RESULT_CODE = 6'h18;
	localparam logic [5:0] OFF_TX_RESULT_FILTER = 6'h1C;
	localparam logic [5:0] OFF_EVENT_ENABLE_MASK = 6'h20;
	localparam logic [5:0] OFF_EVENT_FLAGS = 6'h24;
	localparam int QUEUE_DEPTH = 16;
	localparam logic [1:0] PRIO_RESET = 2'h0;
	localparam logic [1:0] PRIO_ILLEGAL = 2'h3;
	localparam logic [1:0] PRIO_CLAMP = 2'h2;
	localparam logic [1:0] CODE_DONE = 2'h0;
	localparam logic [1:0] CODE_ERROR = 2'h1;
	localparam logic [1:0] CODE_TIMEOUT = 2'h2;
	localparam int FLT_COMPLETED_BIT = 0;
	localparam int FLT_ERROR_BIT = 1;
	localparam int EV_RX_BIT = 0;
	localparam int EV_TX_DONE_BIT = 1;
	localparam int EV_OVERRUN_BIT = 2;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic [1:0] FILTER_RESET = 2'h0;
	localparam logic [2:0] EVENT_RESET = 3'h0;
endpackage : dbm_pkg

// File: src/dbm_fifo.sv
/*
 small synchronous fifo with valid/ready on both sides and a level count.
 assumes a single clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module dbm_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [7:0] level
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [7:0] level_r;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// handshake and head
	assign in_ready = (level_r < 8'(DEPTH));
	assign out_valid = (level_r != 8'h00);
	assign out_data = mem_r[rd_ptr_r];
	assign level = level_r;

	// pointer wrap
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction : bump

	// storage and pointers
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
		if (sys_rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			level_r <= 8'h00;
		end else begin
			if (push) begin
				wr_ptr_r <= bump(wr_ptr_r);
			end
			if (pop) begin
				rd_ptr_r <= bump(rd_ptr_r);
			end
			level_r <= level_r + 8'(push) - 8'(pop);
		end
	end
endmodule : dbm_fifo

// File: src/dbm_regs.sv
/*
 doorbell message register bank with inbound, outbound and completion queues.
 the inbound and completion queues are plain fifos of DEPTH words; the outbound
 side has a two-entry staging buffer in front of the transmit path.
 assumes a slave port where a read returns data one cycle after the strobe,
 and link-side logic on the same clock with valid/ready handshakes.
 assumes the transmit path reports its own level, which is shown as is.
 a transmit word written while the staging buffer is full and not draining is lost,
 so software should watch the transmit level before it queues more.
*/
// Functional notes
// - all registers reachable through the slave port
// - ten word registers, offsets 0x00 to 0x24
// - received head: initiator id and information
// - received count in low byte, max 16
// - priority write of 3 stored as 2
// - transmit word: target id and information
// - pending responses count in bits 23:16
// - transmit path level in bits 15:8, staging entries not counted
// - completion queue count in bits 7:0
// - completion head returned on read
// - code of last read completion kept
// - codes: done 0, error 1, timeout 2
// - filter bits gate completion storage
// - write-one-clear flags, enables, sticky overrun
`timescale 1ns/1ps
module dbm_regs #(
	parameter int DEPTH = dbm_pkg::QUEUE_DEPTH,
	parameter bit LARGE_ID = 1'b1
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [5:0] reg_addr,
	input wire logic reg_read,
	input wire logic reg_write,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic [31:0] rx_message,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [33:0] tx_request,
	input wire logic tx_sent,
	input wire logic cpl_valid,
	input wire logic [31:0] cpl_message,
	input wire logic [1:0] cpl_code,
	input wire logic [7:0] tx_fifo_level,
	output logic event_irq
);
	logic [1:0] prio_r;
	logic [31:0] tx_word_r;
	logic [1:0] result_code_r;
	logic [1:0] filter_r;
	logic [2:0] enable_r;
	logic [2:0] flags_r;
	logic [2:0] flags_nxt;
	logic [7:0] pending_r;
	logic [31:0] rdata_r;
	logic rvalid_r;
	logic [33:0] stage_r [2];
	logic [1:0] stage_cnt_r;
	logic stage_rd_r;

	wire [31:0] rxq_head;
	wire rxq_valid;
	wire [7:0] rxq_level;
	wire [33:0] cq_head;
	wire cq_valid;
	wire cq_in_ready;
	wire [7:0] cq_level;

	////////////////////////////////////////////////////////////////////////
	// address decode
	// unaligned and unmapped offsets hit nothing and read as zero
	wire hit_rx_head = (reg_addr == dbm_pkg::OFF_RX_MESSAGE_HEAD);
	wire hit_rx_cnt = (reg_addr == dbm_pkg::OFF_RX_QUEUE_COUNT);
	wire hit_prio = (reg_addr == dbm_pkg::OFF_TX_REQUEST_PRIORITY);
	wire hit_tx_word = (reg_addr == dbm_pkg::OFF_TX_MESSAGE_WORD);
	wire hit_tx_cnt = (reg_addr == dbm_pkg::OFF_TX_PROGRESS_COUNTS);
	wire hit_res_head = (reg_addr == dbm_pkg::OFF_TX_RESULT_HEAD);
	wire hit_res_code = (reg_addr == dbm_pkg::OFF_TX_RESULT_CODE);
	wire hit_filter = (reg_addr == dbm_pkg::OFF_TX_RESULT_FILTER);
	wire hit_enable = (reg_addr == dbm_pkg::OFF_EVENT_ENABLE_MASK);
	wire hit_flags = (reg_addr == dbm_pkg::OFF_EVENT_FLAGS);

	// read and write side effects
	wire rx_pop = reg_read && hit_rx_head && rxq_valid;
	wire cq_pop = reg_read && hit_res_head && cq_valid;
	wire tx_push = reg_write && hit_tx_word;
	wire stage_full = (stage_cnt_r == 2'h2);
	wire stage_take = tx_valid && tx_ready;

	// completion filter and overrun detection
	wire cpl_is_done = (cpl_code == dbm_pkg::CODE_DONE);
	wire cpl_keep = cpl_is_done ? filter_r[dbm_pkg::FLT_COMPLETED_BIT] : filter_r[dbm_pkg::FLT_ERROR_BIT];
	wire cq_push = cpl_valid && cpl_keep;
	wire cq_overrun = cq_push && !cq_in_ready;

	// upper id byte masking when only 8-bit ids apply
	function automatic logic [31:0] id_mask(input logic [31:0] w);
		id_mask = LARGE_ID ? w : {8'h00, w[23:0]};
	endfunction : id_mask

	// priority clamp
	function automatic logic [1:0] prio_fix(input logic [1:0] p);
		prio_fix = (p == dbm_pkg::PRIO_ILLEGAL) ? dbm_pkg::PRIO_CLAMP : p;
	endfunction : prio_fix

	////////////////////////////////////////////////////////////////////////
	// inbound queue
	dbm_fifo #(.WIDTH(32), .DEPTH(DEPTH)) u_rx_fifo (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.in_valid(rx_valid),
		.in_ready(rx_ready),
		.in_data(rx_message),
		.out_valid(rxq_valid),
		.out_ready(rx_pop),
		.out_data(rxq_head),
		.level(rxq_level)
	);

	// completion queue holds message and outcome
	dbm_fifo #(.WIDTH(34), .DEPTH(DEPTH)) u_cpl_fifo (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.in_valid(cq_push),
		.in_ready(cq_in_ready),
		.in_data({cpl_code, cpl_message}),
		.out_valid(cq_valid),
		.out_ready(cq_pop),
		.out_data(cq_head),
		.level(cq_level)
	);

	////////////////////////////////////////////////////////////////////////
	// one word per register, reserved bits zero
	wire [31:0] word_rx_head = rxq_valid ? id_mask(rxq_head) : dbm_pkg::WORD_RESET;
	wire [31:0] word_rx_cnt = {24'h00_0000, rxq_level};
	wire [31:0] word_prio = {30'h0000_0000, prio_r};
	wire [31:0] word_tx_word = id_mask(tx_word_r);
	wire [31:0] word_tx_cnt = {8'h00, pending_r, tx_fifo_level, cq_level};
	wire [31:0] word_res_head = cq_valid ? id_mask(cq_head[31:0]) : dbm_pkg::WORD_RESET;
	wire [31:0] word_res_code = {30'h0000_0000, result_code_r};
	wire [31:0] word_filter = {30'h0000_0000, filter_r};
	wire [31:0] word_enable = {29'h0000_0000, enable_r};
	wire [31:0] word_flags = {29'h0000_0000, flags_r};

	// read mux
	wire [31:0] rd_mux =
		hit_rx_head ? word_rx_head :
		hit_rx_cnt ? word_rx_cnt :
		hit_prio ? word_prio :
		hit_tx_word ? word_tx_word :
		hit_tx_cnt ? word_tx_cnt :
		hit_res_head ? word_res_head :
		hit_res_code ? word_res_code :
		hit_filter ? word_filter :
		hit_enable ? word_enable :
		hit_flags ? word_flags :
		dbm_pkg::WORD_RESET; // unmapped reads zero

	// read data register
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rdata_r <= dbm_pkg::WORD_RESET;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= reg_read;
			if (reg_read) begin
				rdata_r <= rd_mux;
			end
		end
	end
	assign reg_rdata = rdata_r;
	assign reg_rvalid = rvalid_r;

	////////////////////////////////////////////////////////////////////////
	// priority, clamped on write
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			prio_r <= dbm_pkg::PRIO_RESET;
		end else if (reg_write && hit_prio) begin
			prio_r <= prio_fix(reg_wdata[1:0]);
		end
	end

	// transmit word as last written
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tx_word_r <= dbm_pkg::WORD_RESET;
		end else if (reg_write && hit_tx_word) begin
			tx_word_r <= id_mask(reg_wdata);
		end
	end

	// completion filter
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			filter_r <= dbm_pkg::FILTER_RESET;
		end else if (reg_write && hit_filter) begin
			filter_r <= reg_wdata[1:0];
		end
	end

	// event enables
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			enable_r <= dbm_pkg::EVENT_RESET;
		end else if (reg_write && hit_enable) begin
			enable_r <= reg_wdata[2:0];
		end
	end

	// outcome of the last completion read
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			result_code_r <= dbm_pkg::CODE_DONE;
		end else if (cq_pop) begin
			result_code_r <= cq_head[33:32];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flags: set wins over write-one clear; overrun holds until a pop
	// a clear of the overrun bit is ignored until a completion has been read
	wire ev_rx_set = rx_valid && rx_ready; // any accepted inbound message
	wire ev_done_set = cq_push; // completion passed by the filter, even if the queue is full
	wire ev_overrun_set = cq_overrun; // completion lost to a full queue
	wire [2:0] flag_set = {ev_overrun_set, ev_done_set, ev_rx_set};
	wire [2:0] flag_clr = (reg_write && hit_flags) ? reg_wdata[2:0] : 3'h0;
	wire overrun_locked = flags_r[dbm_pkg::EV_OVERRUN_BIT] && !cq_pop && !stage_rd_r;
	always_comb begin
		flags_nxt = (flags_r & ~flag_clr) | flag_set;
		if (overrun_locked) begin
			flags_nxt[dbm_pkg::EV_OVERRUN_BIT] = 1'b1;
		end
	end
	// flag register
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			flags_r <= dbm_pkg::EVENT_RESET;
		end else begin
			flags_r <= flags_nxt;
		end
	end

	// notes that a completion was read since the last overrun
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			stage_rd_r <= 1'b0;
		end else if (cq_pop) begin
			stage_rd_r <= 1'b1; // one read has happened since overrun
		end else if (ev_overrun_set) begin
			stage_rd_r <= 1'b0;
		end
	end
	assign event_irq = |(flags_r & enable_r);

	////////////////////////////////////////////////////////////////////////
	// pending count: up per sent doorbell, down per response
	wire pend_up = tx_sent && (pending_r < 8'(DEPTH)); // saturates at DEPTH
	wire pend_down = cpl_valid && (pending_r != 8'h00); // floor at zero
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pending_r <= 8'h00;
		end else begin
			pending_r <= pending_r + 8'(pend_up) - 8'(pend_down);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// two-entry staging buffer toward the transmit side
	wire stage_accept = tx_push && (!stage_full || stage_take); // full and stalled drops the word
	wire stage_slot = stage_take ? stage_cnt_r[1] : stage_cnt_r[0]; // first free entry after the shift
	assign tx_valid = (stage_cnt_r != 2'h0);
	assign tx_request = stage_r[0];

	// entry count
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			stage_cnt_r <= 2'h0;
		end else begin
			stage_cnt_r <= stage_cnt_r + 2'(stage_accept) - 2'(stage_take);
		end
	end

	// entry contents: shift on a take, then fill the free slot
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			stage_r[0] <= 34'h0;
			stage_r[1] <= 34'h0;
		end else begin
			if (stage_take) begin
				stage_r[0] <= stage_r[1];
			end
			if (stage_accept) begin
				stage_r[stage_slot] <= {prio_r, id_mask(reg_wdata)};
			end
		end
	end
endmodule : dbm_regs

// File: tb/dbm_regs_properties.sv
/*
 port checker for the doorbell register bank.
 assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module dbm_regs_properties (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [5:0] reg_addr,
	input wire logic reg_read,
	input wire logic reg_write,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [33:0] tx_request,
	input wire logic [7:0] tx_fifo_level
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////
	// register port answers and field contents
	property p_rd; reg_read |=> reg_rvalid; endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	property p_unmap; reg_read && reg_addr > 6'h24 |=> reg_rdata == 32'h0000_0000; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_prio; reg_write && reg_addr == 6'h08 && reg_wdata[1:0] == 2'h3 ##1 !reg_write
		##1 reg_read && reg_addr == 6'h08 |=> reg_rdata[1:0] == 2'h2; endproperty
	a_prio: assert property (p_prio) else $error("priority not clamped");
	property p_code; reg_read && reg_addr == 6'h18 |=> reg_rdata[31:2] == 0 && reg_rdata[1:0] != 2'h3; endproperty
	a_code: assert property (p_code) else $error("bad completion code");
	property p_level; reg_read && reg_addr == 6'h10 |=> reg_rdata[15:8] == $past(tx_fifo_level); endproperty
	a_level: assert property (p_level) else $error("transmit level wrong");
	// outbound queueing and handshake, then cover points
	property p_txq; reg_write && reg_addr == 6'h0C && !tx_valid |=> tx_valid; endproperty
	a_txq: assert property (p_txq) else $error("write did not queue");
	property p_txw; reg_write && reg_addr == 6'h0C && !tx_valid |=> tx_request[31:0] == $past(reg_wdata); endproperty
	a_txw: assert property (p_txw) else $error("queued word wrong");
	property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_request); endproperty
	a_hold: assert property (p_hold) else $error("request dropped while stalled");
	c_pop: cover property (reg_read && reg_addr == 6'h00 ##1 reg_rvalid);
	c_take: cover property (tx_valid && tx_ready);
	c_clamp: cover property (reg_write && reg_addr == 6'h08 && reg_wdata[1:0] == 2'h3);
endmodule : dbm_regs_properties
bind dbm_regs dbm_regs_properties u_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
	.reg_read(reg_read), .reg_write(reg_write), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.reg_rvalid(reg_rvalid), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_request(tx_request),
	.tx_fifo_level(tx_fifo_level));

// File: tb/dbm_link_model.sv
/*
 link-side model: pushes inbound doorbells, takes outbound requests, sends completions.
 assumes the bank's clock; drives at the falling edge.
*/
`timescale 1ns/1ps
module dbm_link_model (
	input wire logic clk_sys,
	input wire logic stall,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [31:0] rx_message,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [33:0] tx_request,
	output logic tx_sent,
	output logic cpl_valid,
	output logic [31:0] cpl_message,
	output logic [1:0] cpl_code
);
	logic [33:0] got[$];
	initial {rx_valid, rx_message, tx_ready, tx_sent, cpl_valid, cpl_message, cpl_code} = '0;
	////////////////////////////////////////
	// random ready gives prompt and slow takes; a take counts as sent
	always @(negedge clk_sys) begin
		tx_ready = !stall && ($urandom_range(1) == 1);
		tx_sent = tx_ready && tx_valid;
		if (tx_sent)
			got.push_back(tx_request);
	end
	// push holds until taken, then the data line turns over
	task automatic push(input logic [31:0] m);
		@(negedge clk_sys);
		rx_valid = 1;
		rx_message = m;
		while (!rx_ready)
			@(negedge clk_sys);
		@(negedge clk_sys);
		rx_valid = 0;
		rx_message = ~m;
	endtask : push
	// one completion pulse with its content
	task automatic cpl(input logic [31:0] m, input logic [1:0] c);
		@(negedge clk_sys);
		cpl_valid = 1;
		cpl_message = m;
		cpl_code = c;
		@(negedge clk_sys);
		cpl_valid = 0;
		cpl_message = ~m;
		cpl_code = ~c;
	endtask : cpl
endmodule : dbm_link_model

// File: tb/doorbell_message_registers_tb.sv
/*
 self-checking bench for the doorbell register bank.
 assumes the link model on the far side and the bound checker.
*/
`timescale 1ns/1ps
module doorbell_message_registers_tb;
	logic clk_sys = 0, sys_rst = 1, reg_read = 0, reg_write = 0, stall = 0;
	logic [5:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0, reg_rdata, q, rx_message, cpl_message;
	logic [7:0] tx_fifo_level = 0;
	logic reg_rvalid, rx_valid, rx_ready, tx_valid, tx_ready, tx_sent, cpl_valid, event_irq;
	logic [1:0] cpl_code;
	logic [33:0] tx_request;
	logic [31:0] mq[$];
	int mismatches = 0, cmp_count = 0, cyc = 0, n;
	dbm_regs dut (.*);
	dbm_link_model lnk (.*);
	always #4 clk_sys = ~clk_sys;
	////////////////////////////////////////
	// one register access, then an idle cycle
	task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
		reg_write = w;
		reg_read = !w;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk_sys);
		reg_write = 0;
		reg_read = 0;
		q = reg_rdata;
		@(negedge clk_sys);
	endtask : acc
	task automatic chk(input logic [33:0] g, input logic [33:0] e);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic chk_req(input int i, input logic [33:0] e);
		chk(lnk.got[i], e);
	endtask : chk_req
	task automatic chk_irq(input logic e);
		chk({33'h0, event_irq}, {33'h0, e});
	endtask : chk_irq
	function automatic logic [31:0] prio_exp(input logic [1:0] p);
		return (p == 2'h3) ? 32'h0000_0002 : {30'h0, p};
	endfunction : prio_exp
	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	// hang guard
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			summarize();
		end
	end
	// main sequence
	initial begin
		n = $urandom(21245);
		repeat (20) @(negedge clk_sys);
		sys_rst = 0;
		for (int a = 0; a <= 40; a += 4) begin
			acc(0, a[5:0], 0);
			chk(q, 0);
		end
		for (int p = 0; p < 4; p++) begin
			acc(1, 6'h08, ($urandom << 2) | p);
			acc(0, 6'h08, 0);
			chk(q, prio_exp(p[1:0]));
		end
		repeat (16) begin
			mq.push_back($urandom);
			lnk.push(mq[$]);
		end
		acc(0, 6'h04, 0);
		chk(q, 16);
		acc(0, 6'h24, 0);
		chk(q[0], 1);
		while (mq.size()) begin
			acc(0, 6'h00, 0);
			chk(q, mq.pop_front());
		end
		acc(0, 6'h04, 0);
		chk(q, 0);
		// three words into a stalled two-entry buffer
		acc(1, 6'h08, 1);
		stall <= 1;
		repeat (3) begin
			mq.push_back($urandom);
			acc(1, 6'h0C, mq[$]);
		end
		stall <= 0;
		repeat (40) @(negedge clk_sys);
		chk(lnk.got.size(), 2);
		for (int i = 0; i < 2; i++)
			chk_req(i, {2'h1, mq[i]});
		mq.delete();
		tx_fifo_level = $urandom_range(16);
		acc(0, 6'h10, 0);
		chk(q, {8'h00, 8'h02, tx_fifo_level, 8'h00});
		// every completion code, then the filter
		acc(1, 6'h1C, 3);
		for (int c = 0; c < 3; c++) begin
			mq.push_back($urandom);
			lnk.cpl(mq[$], c[1:0]);
		end
		acc(0, 6'h10, 0);
		chk(q, {16'h0000, tx_fifo_level, 8'h03});
		for (int c = 0; c < 3; c++) begin
			acc(0, 6'h14, 0);
			chk(q, mq[c]);
			acc(0, 6'h18, 0);
			chk(q, c);
		end
		acc(1, 6'h1C, 1);
		lnk.cpl(32'h0000_00A5, 2'h1);
		lnk.cpl(32'h0000_005A, 2'h0);
		acc(0, 6'h14, 0);
		chk(q, 32'h0000_005A);
		acc(1, 6'h20, 2);
		chk_irq(1);
		acc(1, 6'h24, 7);
		chk_irq(0);
		// overrun: seventeen completions into sixteen entries, sticky until a read
		repeat (17)
			lnk.cpl($urandom, 2'h0);
		acc(0, 6'h10, 0);
		chk(q, {16'h0000, tx_fifo_level, 8'h10});
		acc(1, 6'h24, 7);
		acc(0, 6'h24, 0);
		chk(q, 32'h0000_0004);
		acc(0, 6'h14, 0);
		acc(1, 6'h24, 4);
		acc(0, 6'h24, 0);
		chk(q, 0);
		acc(0, 6'h10, 0);
		chk(q, {16'h0000, tx_fifo_level, 8'h0F});
		summarize();
	end
endmodule : doorbell_message_registers_tb
